// File: qpc_cfg.svh
// Offsets, field positions, reset values and timing counts of the quadrature position counter.
`ifndef QPC_CFG_SVH
`define QPC_CFG_SVH

`define QPC_CLK_MHZ 100
`define QPC_TICK_NS 500
`define QPC_TICK_CYCLES ((`QPC_TICK_NS * `QPC_CLK_MHZ + 999) / 1000)
`define QPC_MAX_PULSE_KHZ 6000

`define QPC_NUM_CH 3
`define QPC_OFF_CTRL 8'h00
`define QPC_OFF_CH_BASE 8'h10
`define QPC_SUB_CFG 2'h0
`define QPC_SUB_LO 2'h1
`define QPC_SUB_HI 2'h2
`define QPC_SUB_STAT 2'h3

`define QPC_CTRL_START_BIT 0
`define QPC_CTRL_STOP_BIT 1
`define QPC_CTRL_SCAN_BIT 2
`define QPC_CFG_RST 32'h0000_0002

`define QPC_DEB_T0 16'h0001
`define QPC_DEB_T1 16'h0002
`define QPC_DEB_T2 16'h0004
`define QPC_DEB_T3 16'h0008
`define QPC_DEB_T4 16'h0010
`define QPC_DEB_T5 16'h0020
`define QPC_DEB_T6 16'h0040
`define QPC_DEB_T7 16'h0080
`define QPC_DEB_T8 16'h0100
`define QPC_DEB_T9 16'h0200
`define QPC_DEB_T10 16'h0400
`define QPC_DEB_T11 16'h0800
`define QPC_DEB_T12 16'h1000
`define QPC_DEB_T13 16'h2000
`define QPC_DEB_T14 16'h4000
`define QPC_DEB_T15 16'hc738

`endif

// File: qpc_debounce.sv
// Input synchroniser, inverter and debounce filter for one encoder input.
`default_nettype none
`include "qpc_cfg.svh"
module qpc_debounce (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin and 500 ns time base.
  input wire logic pin_raw,
  input wire logic tick,
  // Filter setup.
  input wire qpc_pkg::qpc_filt_s filt,
  // Filtered level.
  output logic pin_filt
);

  qpc_pkg::qpc_deb_s state_reg;
  qpc_pkg::qpc_deb_s state_next;
  logic [15:0] limit;
  logic level;

  always_comb begin
    case (filt.time_sel) // RQ8
      4'h0: limit = `QPC_DEB_T0;
      4'h1: limit = `QPC_DEB_T1;
      4'h2: limit = `QPC_DEB_T2;
      4'h3: limit = `QPC_DEB_T3;
      4'h4: limit = `QPC_DEB_T4;
      4'h5: limit = `QPC_DEB_T5;
      4'h6: limit = `QPC_DEB_T6;
      4'h7: limit = `QPC_DEB_T7;
      4'h8: limit = `QPC_DEB_T8;
      4'h9: limit = `QPC_DEB_T9;
      4'ha: limit = `QPC_DEB_T10;
      4'hb: limit = `QPC_DEB_T11;
      4'hc: limit = `QPC_DEB_T12;
      4'hd: limit = `QPC_DEB_T13;
      4'he: limit = `QPC_DEB_T14;
      default: limit = `QPC_DEB_T15;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.sync1 = pin_raw; // RQ17
    state_next.sync2 = state_reg.sync1; // RQ17
    level = state_reg.sync2 ^ filt.invert; // RQ15
    if (filt.bypass) begin
      state_next.out = level; // RQ15
      state_next.last = level;
      state_next.cnt = 16'h0000;
    end else if (level != state_reg.last) begin
      // Any change restarts the stability count.
      state_next.last = level;
      state_next.cnt = 16'h0000;
      if (filt.before_mode && state_reg.cnt >= limit && level != state_reg.out) begin
        state_next.out = level; // RQ14
      end
    end else begin
      if (tick && state_reg.cnt < limit) begin
        state_next.cnt = state_reg.cnt + 16'h0001;
      end
      // After-stable edges and the catch-up of a before-stable output both land here.
      if (state_reg.cnt >= limit && level != state_reg.out) begin
        state_next.out = level; // RQ13
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_filt = state_reg.out;

endmodule
`default_nettype wire

// File: qpc_encoder_model.sv
// Behavioural three-channel shaft encoder with lead, quadrature and index lines.
`default_nettype none
module qpc_encoder_model (
  // Clock that paces the steps.
  input wire logic pclk,
  // Encoder lines per channel.
  output logic [2:0] lead,
  output logic [2:0] quad,
  output logic [2:0] index
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lead = 3'h0;
    quad = 3'h0;
    index = 3'h0;
  end
  // Five cycles a quarter gives 5 MHz pulses, below the supported maximum.
  task automatic move(input int ch, input bit fwd, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (5) @(posedge pclk);
      if ((lead[ch] == quad[ch]) == fwd) lead[ch] <= ~lead[ch];
      else quad[ch] <= ~quad[ch];
    end
  endtask
  task automatic level(input int ch, input bit v, input int hold);
    @(posedge pclk);
    lead[ch] <= v;
    repeat (hold) @(posedge pclk);
  endtask
  task automatic mark(input int ch);
    @(posedge pclk);
    index[ch] <= 1'b1;
    repeat (5) @(posedge pclk);
    index[ch] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: qpc_pkg.sv
// Types shared by the quadrature position counter modules.
`default_nettype none
package qpc_pkg;

  typedef enum logic [1:0] {
    single_edge_mode = 2'b00,
    double_edge_mode = 2'b01,
    quad_edge_mode = 2'b10
  } qpc_res_e;

  typedef struct packed {
    logic invert;
    logic bypass;
    logic before_mode;
    logic [3:0] time_sel;
  } qpc_filt_s;

  typedef struct packed {
    logic pad3;
    qpc_filt_s z;
    logic pad2;
    qpc_filt_s b;
    logic pad1;
    qpc_filt_s a;
    logic [3:0] pad0;
    logic idx_zero;
    logic wide32;
    qpc_res_e res;
  } qpc_chcfg_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic out;
    logic [15:0] cnt;
  } qpc_deb_s;

  typedef struct packed {
    logic [15:0] tick_cnt;
    logic acq_active;
    logic [2:0] pa;
    logic [2:0] pb;
    logic [2:0] pz;
    logic [2:0] ref_valid;
    logic [2:0][31:0] count;
    logic [2:0][31:0] latch;
    logic [2:0][31:0] cfg;
    logic [31:0] prdata;
    logic pslverr;
  } qpc_top_s;

endpackage
`default_nettype wire

// File: qpc_top.sv
// Three-channel quadrature position counter with APB register access.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`default_nettype none
`include "qpc_cfg.svh"
// What this block does and what its software must do
// RQ1: Count up when phase A leads phase B, down when it lags.
// RQ2: Resolution selects single-edge, double-edge or quad-edge counting.
// RQ3: With index zeroing enabled, an index pulse resets the count to zero.
// RQ4: Each counter works as a 16-bit word or a 32-bit value.
// RQ5: Pulse trains up to 6 MHz are counted; the encoder stays below that.
// RQ6: Three independent channels, each with lead, quadrature and index inputs.
// RQ7: Encoder inputs serve only counting; no remapping to other functions.
// RQ8: Each input has a debounce filter with sixteen selectable times.
// RQ9: Starting an acquisition clears every counter, so scan one reads zero.
// RQ10: Each start-of-scan strobe during an acquisition copies every counter into its holding register.
// RQ11: Index-referenced position is flagged invalid until the first index pulse.
// RQ12: Software using a counter as trigger sets a threshold of at least one.
// RQ13: After-stable mode changes output only after the new level held long enough.
// RQ14: Before-stable mode follows an edge at once if the input was stable.
// RQ15: Each input has a selectable inverter and a debounce bypass.
// RQ16: All timing, debounce time base included, comes from the one system clock.
// RQ17: Encoder inputs pass two flip-flops before any decoding.
// RQ18: Latched low and high words come from the same capture instant.
module qpc_top #(
  parameter int TICK_CYCLES = `QPC_TICK_CYCLES
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Acquisition engine strobes.
  input wire logic acq_start,
  input wire logic acq_stop,
  input wire logic scan_strobe,
  // Encoder pins.
  input wire logic enc0_phase_lead,
  input wire logic enc0_phase_quad,
  input wire logic enc0_index,
  input wire logic enc1_phase_lead,
  input wire logic enc1_phase_quad,
  input wire logic enc1_index,
  input wire logic enc2_phase_lead,
  input wire logic enc2_phase_quad,
  input wire logic enc2_index,
  // Scan data towards the acquisition engine.
  output logic [2:0][31:0] scan_count,
  output logic [2:0] ref_valid,
  output logic acq_active
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES must lie between 1 and 65535");
  end

  qpc_pkg::qpc_top_s state_reg;
  qpc_pkg::qpc_top_s state_next;
  logic [2:0][2:0] raw;
  logic [2:0][2:0] flt;
  logic tick;

  // Lead, quadrature and index pins are wired straight to their debounce filter only.
  assign raw[0] = {enc0_index, enc0_phase_quad, enc0_phase_lead}; // RQ7
  assign raw[1] = {enc1_index, enc1_phase_quad, enc1_phase_lead}; // RQ7
  assign raw[2] = {enc2_index, enc2_phase_quad, enc2_phase_lead}; // RQ7

  // The debounce time base is a divided pclk enable, so no second clock exists.
  assign tick = (state_reg.tick_cnt == 16'(TICK_CYCLES - 1)); // RQ16

  for (genvar ch = 0; ch < `QPC_NUM_CH; ch++) begin : g_ch // RQ6
    for (genvar k = 0; k < 3; k++) begin : g_in
      qpc_pkg::qpc_chcfg_s chcfg;
      qpc_pkg::qpc_filt_s filt;
      assign chcfg = qpc_pkg::qpc_chcfg_s'(state_reg.cfg[ch]);
      assign filt = (k == 0) ? chcfg.a : (k == 1) ? chcfg.b : chcfg.z;
      qpc_debounce u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .pin_raw(raw[ch][k]),
        .tick(tick),
        .filt(filt),
        .pin_filt(flt[ch][k])
      ); // RQ8
    end
  end

  always_comb begin
    logic setup;
    logic wr;
    logic start;
    logic stop;
    logic scan;
    logic [1:0] ch_sel;
    logic [1:0] sub;
    logic a;
    logic b;
    logic z;
    logic a_r;
    logic a_f;
    logic b_r;
    logic b_f;
    logic z_r;
    logic step;
    logic up;
    logic [31:0] nxt;
    qpc_pkg::qpc_chcfg_s c;
    state_next = state_reg;
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    ch_sel = 2'(paddr[7:4] - 4'h1);
    sub = paddr[3:2];
    start = acq_start;
    stop = acq_stop;
    scan = scan_strobe;
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    a_r = 1'b0;
    a_f = 1'b0;
    b_r = 1'b0;
    b_f = 1'b0;
    z_r = 1'b0;
    step = 1'b0;
    up = 1'b0;
    nxt = 32'h0000_0000;
    c = '0;

    state_next.tick_cnt = tick ? 16'h0000 : state_reg.tick_cnt + 16'h0001; // RQ16

    // Register writes take effect in the access phase.
    if (wr && paddr == `QPC_OFF_CTRL) begin
      start = start | (pstrb[0] & pwdata[`QPC_CTRL_START_BIT]);
      stop = stop | (pstrb[0] & pwdata[`QPC_CTRL_STOP_BIT]);
      scan = scan | (pstrb[0] & pwdata[`QPC_CTRL_SCAN_BIT]);
    end
    if (wr && paddr[7:4] >= 4'h1 && paddr[7:4] <= 4'h3 && sub == `QPC_SUB_CFG) begin
      for (int by = 0; by < 4; by++) begin
        if (pstrb[by]) begin
          state_next.cfg[ch_sel][by*8 +: 8] = pwdata[by*8 +: 8];
        end
      end
    end

    if (start) begin
      state_next.acq_active = 1'b1;
    end else if (stop) begin
      state_next.acq_active = 1'b0;
    end

    for (int i = 0; i < `QPC_NUM_CH; i++) begin
      c = qpc_pkg::qpc_chcfg_s'(state_reg.cfg[i]);
      a = flt[i][0];
      b = flt[i][1];
      z = flt[i][2];
      state_next.pa[i] = a;
      state_next.pb[i] = b;
      state_next.pz[i] = z;
      // Edges are found on every pclk cycle, so quarter periods near 40 ns still resolve.
      a_r = a & ~state_reg.pa[i]; // RQ5
      a_f = ~a & state_reg.pa[i];
      b_r = b & ~state_reg.pb[i];
      b_f = ~b & state_reg.pb[i];
      z_r = z & ~state_reg.pz[i];
      // In quad-edge mode, edges on both phases in one cycle are a decoding error and are skipped.
      case (c.res) // RQ2
        qpc_pkg::single_edge_mode: step = a_r;
        qpc_pkg::double_edge_mode: step = a_r | a_f;
        qpc_pkg::quad_edge_mode: step = (a_r | a_f | b_r | b_f) & ~((a_r | a_f) & (b_r | b_f));
        default: step = 1'b0;
      endcase
      // Lead ahead of quadrature means upward travel.
      up = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a); // RQ1
      nxt = up ? state_reg.count[i] + 32'h0000_0001 : state_reg.count[i] - 32'h0000_0001;
      if (!c.wide32) begin
        nxt[31:16] = 16'h0000; // RQ4
      end
      if (start) begin
        state_next.count[i] = 32'h0000_0000; // RQ9
      end else if (z_r && c.idx_zero) begin
        state_next.count[i] = 32'h0000_0000; // RQ3
      end else if (step) begin
        state_next.count[i] = nxt; // RQ1
      end else if (!c.wide32) begin
        state_next.count[i][31:16] = 16'h0000; // RQ4
      end

      // Both halves are copied in one edge so split reads stay coherent.
      if (start) begin
        state_next.latch[i] = 32'h0000_0000; // RQ9
      end else if (scan && state_reg.acq_active) begin
        state_next.latch[i] = state_reg.count[i]; // RQ10 RQ18
      end

      // The index edge wins over a clear in the same cycle.
      if (z_r && (state_reg.acq_active || start)) begin
        state_next.ref_valid[i] = 1'b1; // RQ11
      end else if (start) begin
        state_next.ref_valid[i] = 1'b0; // RQ11
      end
    end

    // Read data and error are prepared in the setup phase for a zero-wait access.
    if (setup) begin
      state_next.prdata = 32'h0000_0000;
      state_next.pslverr = 1'b0;
      if (paddr[1:0] != 2'b00) begin
        state_next.pslverr = 1'b1;
      end else if (paddr == `QPC_OFF_CTRL) begin
        state_next.prdata = {31'h0000_0000, state_reg.acq_active};
      end else if (paddr[7:4] >= 4'h1 && paddr[7:4] <= 4'h3) begin
        case (sub)
          `QPC_SUB_CFG: state_next.prdata = state_reg.cfg[ch_sel];
          `QPC_SUB_LO: state_next.prdata = {16'h0000, state_reg.latch[ch_sel][15:0]};
          `QPC_SUB_HI: state_next.prdata = {16'h0000, state_reg.latch[ch_sel][31:16]}; // RQ18
          default: state_next.prdata = {31'h0000_0000, state_reg.ref_valid[ch_sel]};
        endcase
      end else begin
        state_next.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.cfg <= {`QPC_NUM_CH{`QPC_CFG_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign prdata = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign scan_count = state_reg.latch;
  assign ref_valid = state_reg.ref_valid;
  assign acq_active = state_reg.acq_active;

endmodule
`default_nettype wire

// File: qpc_top_monitor.sv
// Checker of the quadrature position counter's port behaviour.
`default_nettype none
module qpc_top_monitor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strobes and scan data.
  input wire logic acq_start,
  input wire logic acq_stop,
  input wire logic scan_strobe,
  input wire logic [2:0][31:0] scan_count,
  input wire logic [2:0] ref_valid,
  input wire logic acq_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctl_wr;
  logic quiet;
  // A control word write acts like the strobes, so it opens every hold window.
  assign ctl_wr = psel && penable && pwrite && paddr == 8'h00;
  assign quiet = !acq_start && !acq_stop && !ctl_wr;
  start_on_a: assert property (acq_start |=> acq_active)
    else $error("acquisition not active after start");
  start_clear_a: assert property (acq_start |=> scan_count == '0)
    else $error("scan data not cleared by start");
  active_hold_a: assert property (quiet |=> $stable(acq_active))
    else $error("acquisition state changed without a strobe");
  idle_hold_a: assert property (!acq_active && quiet |=> $stable(scan_count))
    else $error("scan data changed while idle");
  latch_hold_a: assert property (!scan_strobe && quiet |=> $stable(scan_count))
    else $error("scan data changed without a scan strobe");
  ref_keep_a: assert property (quiet |=> (ref_valid & $past(ref_valid)) == $past(ref_valid))
    else $error("reference flag dropped during acquisition");
  ref_idle_a: assert property (!acq_active && quiet |=> (ref_valid & ~$past(ref_valid)) == 3'h0)
    else $error("reference flag set outside acquisition");
  ctrl_read_a: assert property (psel && penable && !pwrite && paddr == 8'h00 |->
    prdata[0] == $past(acq_active))
    else $error("control read does not show acquisition state");
  cover property (scan_strobe && acq_active);
  cover property ($rose(ref_valid[0]));
  cover property (psel && penable && pslverr);
  cover property (psel && penable && pready && !pwrite);
endmodule
bind qpc_top qpc_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .acq_start(acq_start), .acq_stop(acq_stop), .scan_strobe(scan_strobe),
  .scan_count(scan_count), .ref_valid(ref_valid), .acq_active(acq_active));
`default_nettype wire

// File: test_quadrature_position_counter.sv
// Self-checking bench for the quadrature position counter.
`default_nettype none
module test_quadrature_position_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic acq_start = 1'b0;
  logic acq_stop = 1'b0;
  logic scan_strobe = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] lead;
  logic [2:0] quad;
  logic [2:0] index;
  logic [2:0][31:0] scan_count;
  logic [2:0] ref_valid;
  logic acq_active;
  logic [31:0] rd;
  logic [31:0] e;
  logic er;
  int err_count = 0;
  int comparisons = 0;
  int k;
  int d;
  always #5 pclk = ~pclk;
  qpc_encoder_model enc (.pclk(pclk), .lead(lead), .quad(quad), .index(index));
  qpc_top #(.TICK_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acq_start(acq_start),
    .acq_stop(acq_stop), .scan_strobe(scan_strobe), .enc0_phase_lead(lead[0]),
    .enc0_phase_quad(quad[0]), .enc0_index(index[0]), .enc1_phase_lead(lead[1]),
    .enc1_phase_quad(quad[1]), .enc1_index(index[1]), .enc2_phase_lead(lead[2]),
    .enc2_phase_quad(quad[2]), .enc2_index(index[2]), .scan_count(scan_count),
    .ref_valid(ref_valid), .acq_active(acq_active));
  function automatic logic [31:0] fold(input logic [31:0] v, input bit w);
    return w ? v : {16'h0, v[15:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers.
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int w);
    @(posedge pclk);
    {acq_start, acq_stop, scan_strobe} <= 3'b100 >> w;
    @(posedge pclk);
    {acq_start, acq_stop, scan_strobe} <= 3'b000;
    @(negedge pclk);
  endtask
  task automatic scan(input int ch, input logic [31:0] x);
    repeat (8) @(posedge pclk);
    pulse(2);
    chk(scan_count[ch], x);
  endtask
  initial begin
    void'($urandom(36));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      apb(1'b0, 8'h10 + 8'(c * 16), 32'h0);
      chk(rd, 32'h2);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int r = 0; r < 3; r++) begin
      k = $urandom_range(1, 6);
      apb(1'b1, 8'h10, 32'h2020_2000 | 32'(r));
      apb(1'b1, 8'h20, 32'h2020_2002 | 32'((r & 1) << 2));
      pulse(0);
      chk(scan_count[0], 32'h0);
      enc.move(0, 1'b1, 4 * k);
      enc.move(1, 1'b0, 4 * k);
      e = fold(32'(-4 * k), r[0]);
      scan(0, 32'(k << r));
      // A counter trigger uses a threshold of one, since every run opens at zero.
      chk({31'h0, scan_count[0] >= 32'h1}, 32'h1);
      chk(scan_count[1], e);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, {16'h0, e[15:0]});
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, {16'h0, e[31:16]});
    end
    apb(1'b1, 8'h10, 32'h2020_200a);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    enc.move(0, 1'b1, 6);
    enc.mark(0);
    enc.move(0, 1'b1, 3);
    scan(0, 32'h3);
    chk({29'h0, ref_valid}, 32'h1);
    pulse(1);
    pulse(2);
    chk(scan_count[0], 32'h3);
    apb(1'b1, 8'h30, 32'h2020_0300);
    pulse(0);
    enc.level(2, 1'b1, 6);
    enc.level(2, 1'b0, 40);
    scan(2, 32'h0);
    enc.level(2, 1'b1, 40);
    scan(2, 32'h1);
    enc.level(2, 1'b0, 40);
    apb(1'b1, 8'h30, 32'h2020_1300);
    pulse(0);
    repeat (40) @(posedge pclk);
    enc.level(2, 1'b1, 3);
    enc.level(2, 1'b0, 40);
    scan(2, 32'h1);
    apb(1'b1, 8'h30, 32'h2020_4300);
    repeat (40) @(posedge pclk);
    pulse(0);
    enc.level(2, 1'b1, 40);
    scan(2, 32'h0);
    enc.level(2, 1'b0, 40);
    scan(2, 32'h1);
    apb(1'b1, 8'h30, 32'h2020_2006);
    pulse(0);
    e = 32'h0;
    for (int i = 0; i < 40; i++) begin
      d = $urandom_range(0, 1);
      enc.move(2, d[0], 1);
      e = d[0] ? e + 32'h1 : e - 32'h1;
    end
    scan(2, e);
    enc.move(2, 1'b1, 2);
    e = e + 32'h2;
    repeat (8) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h4);
    @(negedge pclk);
    chk(scan_count[2], e);
    apb(1'b1, 8'h30, 32'h2020_2007);
    pulse(0);
    enc.move(2, 1'b1, 4);
    scan(2, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
  // The sequence needs at most about 1600 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
